// ===== timer8_compare_unit.sv
// Eight-bit timer with one compare channel and an Avalon-MM register slave.
// Assumes all inputs but the asynchronous reset i_arst_n synchronous to i_clk; the prescaler is free running inside.
//
// How it works
// RULE1: Count and compare are 8-bit CPU registers.
// RULE2: Clock select picks prescaler tap or pin.
// RULE3: Clock select zero stops ticks entirely.
// RULE4: CPU count write beats clear and count.
// RULE5: Bottom 0x00, max 0xFF, top by mode.
// RULE6: Tick clears, increments or decrements the counter.
// RULE7: Overflow flag set per mode, raises request.
// RULE8: Equality sets compare flag next tick.
// RULE9: Flags readable, each masked individually.
// RULE10: Request when flag, enable, global on.
// RULE11: Writing one clears a flag.
// RULE12: PWM modes double buffer the compare value.
// RULE13: CPU writes buffer or live compare.
// RULE14: Force strobe acts like match, non-PWM only.
// RULE15: Count write blocks the next tick's match.
// RULE16: Software avoids writing count equal compare.
// RULE17: Output latch survives mode change, resets zero.
// RULE18: Output action bits act immediately.
// RULE19: Nonzero action mode overrides port data.
// RULE20: Action mode zero leaves latch unchanged.
// RULE21: Mode 0 counts up, wraps, overflow.
// RULE22: Mode 2 clears at compare match.
// RULE23: Mode 3 single-slope fast PWM.
// RULE24: Mode 1 dual-slope phase correct PWM.
// RULE25: Tick is a one-cycle enable.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`include "timer8_regs.svh"
module timer8_compare_unit
  import timer8_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_ext_count_pin,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_overflow_irq,
  output logic o_compare_irq,
  output timer8_pkg::byte_type o_count_value
);
  import timer8_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [2:0] clock_select_q;
  wave_mode_type waveform_mode_q;
  logic [1:0] output_action_mode_q;
  byte_type count_value_q;
  byte_type compare_value_q;
  byte_type compare_buf_q;
  logic overflow_flag_q;
  logic compare_flag_q;
  logic overflow_irq_enable_q;
  logic compare_irq_enable_q;
  logic port_data_q;
  logic compare_pin_direction_q;
  logic global_irq_q;
  logic compare_output_q;
  logic count_down_q;
  logic block_q;
  logic ack_q;
  logic [`PRESC_W-1:0] presc_q;
  logic ext_s_q;
  logic ext_prev_q;

  function automatic logic is_pwm(input wave_mode_type m);
    is_pwm = (m == WAVE_PHASE_PWM) || (m == WAVE_FAST_PWM);
  endfunction

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode. Every access is answered one cycle after it is presented.
  logic wr_acc;
  logic rd_acc;
  logic wr_lane0;
  byte_type wbyte;
  // A write lands at the edge where the master samples waitrequest low.
  assign wr_acc = i_avs_write && ack_q;
  assign rd_acc = i_avs_read && !ack_q;
  assign wr_lane0 = wr_acc && i_avs_byteenable[0];
  assign wbyte = i_avs_writedata[7:0];

  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_flag;
  logic wr_mask;
  logic wr_port;
  assign wr_ctrl = wr_lane0 && hit(i_avs_address, `OFF_CONTROL);
  assign wr_count = wr_lane0 && hit(i_avs_address, `OFF_COUNT);
  assign wr_cmp = wr_lane0 && hit(i_avs_address, `OFF_COMPARE);
  assign wr_flag = wr_lane0 && hit(i_avs_address, `OFF_IRQ_FLAG);
  assign wr_mask = wr_lane0 && hit(i_avs_address, `OFF_IRQ_MASK);
  assign wr_port = wr_lane0 && hit(i_avs_address, `OFF_PORT);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock select and timer tick.
  logic tick;
  logic presc_tap;
  always_comb begin
    case (clock_select_q)
      3'h1: presc_tap = 1'b1;
      3'h2: presc_tap = (presc_q[2:0] == 3'h7);
      3'h3: presc_tap = (presc_q[5:0] == 6'h3f);
      3'h4: presc_tap = (presc_q[7:0] == 8'hff);
      3'h5: presc_tap = (presc_q == 10'h3ff);
      3'h6: presc_tap = ext_prev_q && !ext_s_q;
      3'h7: presc_tap = !ext_prev_q && ext_s_q;
      default: presc_tap = 1'b0; // RULE3
    endcase
  end
  assign tick = presc_tap; // RULE2 RULE25

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_q <= '0;
      ext_s_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 10'h001;
      ext_s_q <= i_ext_count_pin;
      ext_prev_q <= ext_s_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter unit.
  logic at_top;
  logic at_bottom;
  logic match;
  logic match_ok;
  assign at_bottom = (count_value_q == `COUNT_BOTTOM); // RULE5
  assign match = (count_value_q == compare_value_q); // RULE8
  assign at_top = (waveform_mode_q == WAVE_CTC) ? match : (count_value_q == `COUNT_MAX); // RULE5
  assign match_ok = tick && match && !block_q; // RULE15

  byte_type count_d;
  logic down_d;
  always_comb begin
    count_d = count_value_q;
    down_d = count_down_q;
    if (tick) begin
      case (waveform_mode_q)
        WAVE_CTC: count_d = match ? `COUNT_BOTTOM : count_value_q + 8'h01; // RULE22
        WAVE_PHASE_PWM: begin
          if (at_top) begin
            down_d = 1'b1;
            count_d = count_value_q - 8'h01; // RULE24
          end else if (at_bottom && count_down_q) begin
            down_d = 1'b0;
            count_d = count_value_q + 8'h01;
          end else begin
            count_d = count_down_q ? count_value_q - 8'h01 : count_value_q + 8'h01; // RULE6
          end
        end
        default: count_d = count_value_q + 8'h01; // RULE21 RULE23
      endcase
      if (waveform_mode_q != WAVE_PHASE_PWM) begin
        down_d = 1'b0;
      end
    end
    if (wr_count) begin
      count_d = wbyte; // RULE4
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_value_q <= `RST_BYTE;
      count_down_q <= 1'b0;
    end else begin
      count_value_q <= count_d; // RULE1
      count_down_q <= down_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1; // RULE15
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare value with double buffer.
  logic pwm_update;
  assign pwm_update = tick && ((waveform_mode_q == WAVE_FAST_PWM) ? at_top :
                               (at_top && !count_down_q));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_buf_q <= `RST_BYTE;
    end else if (wr_cmp) begin
      compare_buf_q <= wbyte; // RULE13
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_value_q <= `RST_BYTE;
    end else if (!is_pwm(waveform_mode_q)) begin
      if (wr_cmp) begin
        compare_value_q <= wbyte; // RULE12 RULE13
      end
    end else if (pwm_update) begin
      compare_value_q <= compare_buf_q; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags, masks and requests.
  logic ovf_event;
  assign ovf_event = tick && ((waveform_mode_q == WAVE_PHASE_PWM) ?
                     (at_bottom && count_down_q) : (count_value_q == `COUNT_MAX)); // RULE7

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_flag_q <= 1'b0;
      overflow_flag_q <= 1'b0;
    end else begin
      if (match_ok) begin
        compare_flag_q <= 1'b1; // RULE8
      end else if ((wr_flag && wbyte[`FLAG_OCF_BIT]) ||
                   (wr_port && wbyte[`PORT_ACK_OCF_BIT])) begin
        compare_flag_q <= 1'b0; // RULE10 RULE11
      end
      if (ovf_event) begin
        overflow_flag_q <= 1'b1; // RULE21
      end else if ((wr_flag && wbyte[`FLAG_TOV_BIT]) ||
                   (wr_port && wbyte[`PORT_ACK_TOV_BIT])) begin
        overflow_flag_q <= 1'b0; // RULE11
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      overflow_irq_enable_q <= 1'b0;
      compare_irq_enable_q <= 1'b0;
    end else if (wr_mask) begin
      overflow_irq_enable_q <= wbyte[`FLAG_TOV_BIT]; // RULE9
      compare_irq_enable_q <= wbyte[`FLAG_OCF_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_compare_irq <= 1'b0;
      o_overflow_irq <= 1'b0;
    end else begin
      o_compare_irq <= compare_flag_q && compare_irq_enable_q && global_irq_q; // RULE10
      o_overflow_irq <= overflow_flag_q && overflow_irq_enable_q && global_irq_q; // RULE7 RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, port and output latch.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clock_select_q <= 3'h0;
      waveform_mode_q <= WAVE_NORMAL;
      output_action_mode_q <= 2'h0;
    end else if (wr_ctrl) begin
      clock_select_q <= wbyte[`CTRL_CS_LSB +: 3];
      waveform_mode_q <= wave_mode_type'(wbyte[`CTRL_WGM_LSB +: 2]);
      output_action_mode_q <= wbyte[`CTRL_COM_LSB +: 2]; // RULE18
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_data_q <= 1'b0;
      compare_pin_direction_q <= 1'b0;
      global_irq_q <= 1'b0;
    end else if (wr_port) begin
      port_data_q <= wbyte[`PORT_DATA_BIT];
      compare_pin_direction_q <= wbyte[`PORT_DIR_BIT];
      global_irq_q <= wbyte[`PORT_GIE_BIT];
    end
  end

  logic force_hit;
  logic oc_d;
  logic [1:0] act_mode;
  assign act_mode = wr_ctrl ? wbyte[`CTRL_COM_LSB +: 2] : output_action_mode_q; // RULE18
  assign force_hit = wr_ctrl && wbyte[`CTRL_FOC_BIT] && !is_pwm(waveform_mode_q); // RULE14
  always_comb begin
    oc_d = compare_output_q; // RULE17 RULE20
    if (match_ok || force_hit) begin
      case (waveform_mode_q)
        WAVE_FAST_PWM: begin
          if (act_mode == 2'h1) oc_d = !compare_output_q;
          else if (act_mode[1]) oc_d = act_mode[0];
        end
        WAVE_PHASE_PWM: begin
          if (act_mode[1]) oc_d = act_mode[0] ^ count_down_q;
        end
        default: begin
          case (act_mode)
            2'h1: oc_d = !compare_output_q;
            2'h2: oc_d = 1'b0;
            2'h3: oc_d = 1'b1;
            default: oc_d = compare_output_q; // RULE20
          endcase
        end
      endcase
    end else if (tick && waveform_mode_q == WAVE_FAST_PWM && at_top &&
                 act_mode[1]) begin
      oc_d = !act_mode[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_output_q <= 1'b0; // RULE17
    end else begin
      compare_output_q <= oc_d; // RULE18
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
      o_count_value <= `RST_BYTE;
    end else begin
      o_pin_out <= (output_action_mode_q != 2'h0) ? oc_d : port_data_q; // RULE19
      o_pin_oe <= compare_pin_direction_q;
      o_count_value <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (rd_acc) begin
      o_avs_readdata <= 32'h00000000;
      case (i_avs_address)
        `OFF_CONTROL: o_avs_readdata[7:0] <= {1'b0, output_action_mode_q,
                                                waveform_mode_q, clock_select_q};
        `OFF_COUNT: o_avs_readdata[7:0] <= count_value_q;
        `OFF_COMPARE: o_avs_readdata[7:0] <= is_pwm(waveform_mode_q) ?
                                             compare_buf_q : compare_value_q;
        `OFF_IRQ_FLAG: o_avs_readdata[1:0] <= {compare_flag_q, overflow_flag_q};
        `OFF_IRQ_MASK: o_avs_readdata[1:0] <= {compare_irq_enable_q, overflow_irq_enable_q};
        `OFF_PORT: o_avs_readdata[3:0] <= {compare_output_q, global_irq_q,
                                           compare_pin_direction_q, port_data_q};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ===== timer8_regs.svh
// Register offsets, field positions, reset values and the prescaler width of the timer.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

`define OFF_CONTROL 5'h00
`define OFF_COUNT 5'h04
`define OFF_COMPARE 5'h08
`define OFF_IRQ_FLAG 5'h0c
`define OFF_IRQ_MASK 5'h10
`define OFF_PORT 5'h14

`define CTRL_CS_LSB 0
`define CTRL_WGM_LSB 3
`define CTRL_COM_LSB 5
`define CTRL_FOC_BIT 7

`define FLAG_TOV_BIT 0
`define FLAG_OCF_BIT 1

`define PORT_DATA_BIT 0
`define PORT_DIR_BIT 1
`define PORT_GIE_BIT 2
`define PORT_ACK_OCF_BIT 3
`define PORT_ACK_TOV_BIT 4

`define RST_BYTE 8'h00
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hff
`define PRESC_W 10
`endif

// ===== timer8_pkg.sv
// Types shared by the timer design.
// Assumes nothing beyond the register header.
package timer8_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PHASE_PWM = 2'h1,
    WAVE_CTC = 2'h2,
    WAVE_FAST_PWM = 2'h3
  } wave_mode_type;
endpackage

// ===== timer8_compare_unit_assertions.sv
// Checker for the timer block: temporal properties on its top ports.
// Assumes it is bound to every timer8_compare_unit instance.
module timer8_checker
  import timer8_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_pin_out,
  input wire logic o_pin_oe,
  input wire logic o_overflow_irq,
  input wire logic o_compare_irq,
  input wire timer8_pkg::byte_type o_count_value
);
  logic [2:0] wr_age_q;
  logic [2:0] cnt_age_q;
  logic just_out_q;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_age_q <= 3'h7;
      cnt_age_q <= 3'h7;
      just_out_q <= 1'b1;
    end else begin
      wr_age_q <= i_avs_write ? 3'h0 : (wr_age_q == 3'h7 ? wr_age_q : wr_age_q + 3'h1);
      cnt_age_q <= $changed(o_count_value) ? 3'h0 : (cnt_age_q == 3'h7 ? 3'h7 : cnt_age_q + 3'h1);
      just_out_q <= 1'b0;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  property p_answer; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered after one cycle");
  property p_rd_hi; !o_avs_waitrequest && i_avs_read |-> o_avs_readdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("read data above the byte not zero");
  property p_reset_vals; just_out_q |-> !o_pin_out && o_count_value == 8'h00 && o_avs_waitrequest;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset values");
  property p_count_step;
    $changed(o_count_value) |-> o_count_value == $past(o_count_value) + 8'h01 ||
      o_count_value == $past(o_count_value) - 8'h01 || o_count_value == 8'h00 || wr_age_q < 3'h4;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter moved by more than one step");
  property p_cmp_irq_fall; $fell(o_compare_irq) |-> wr_age_q < 3'h4; endproperty
  a_cmp_irq_fall: assert property (p_cmp_irq_fall)
    else $error("compare request dropped without a write");
  property p_ovf_irq_fall; $fell(o_overflow_irq) |-> wr_age_q < 3'h4; endproperty
  a_ovf_irq_fall: assert property (p_ovf_irq_fall)
    else $error("overflow request dropped without a write");
  property p_oe_cause; $changed(o_pin_oe) |-> wr_age_q < 3'h4; endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin enable changed without a write");
  property p_pin_cause;
    $changed(o_pin_out) |-> $changed(o_count_value) || cnt_age_q < 3'h3 || wr_age_q < 3'h4;
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin changed without tick or write");
  c_cmp_irq: cover property ($rose(o_compare_irq));
  c_pin: cover property ($changed(o_pin_out));
  c_wrap: cover property ($past(o_count_value) == 8'hff && o_count_value == 8'h00);
endmodule
bind timer8_compare_unit timer8_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_overflow_irq(o_overflow_irq), .o_compare_irq(o_compare_irq),
  .o_count_value(o_count_value));

// ===== ext_count_source.sv
// Partner model: external event source on the timer's count pin.
// Assumes the bench raises i_run only while edges are wanted; the pin holds otherwise.
module ext_count_source (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [3:0] i_half,
  output logic o_pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q = 4'h0;
  // Half periods of two or more cycles keep the pin sampler safe.
  always @(posedge i_clk) begin
    if (i_run) begin
      cnt_q <= (cnt_q + 4'h1 >= i_half) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q + 4'h1 >= i_half) o_pin <= !o_pin;
    end
  end
endmodule

// ===== timer8_compare_unit_tb.sv
// Self-checking bench for the timer: bus tasks, a register model and mode scenarios.
// Assumes the checker is bound in and the partner drives the count pin.
module timer8_compare_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import timer8_pkg::*;
  localparam int MSK[6] = '{8'h7f, 8'hff, 8'hff, 0, 3, 7};
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rv, v;
  logic [31:0] seed = 32'he5ef;
  logic avs_waitrequest, ext_pin, pin_out, pin_oe, ovf_irq, cmp_irq, pl;
  logic run = 1'b0;
  byte_type count_value, pc;
  int err_count = 0;
  int checks_done = 0;
  int edges = 0;
  int fedges = 0;
  int m[6] = '{default: 0};
  int mx, tg, n, dec;
  always #20 i_clk = ~i_clk;
  always @(posedge ext_pin) edges++;
  always @(negedge ext_pin) fedges++;
  timer8_compare_unit dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_ext_count_pin(ext_pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_overflow_irq(ovf_irq),
    .o_compare_irq(cmp_irq), .o_count_value(count_value));
  ext_count_source u_src (.i_clk(i_clk), .i_run(run), .i_half(4'h3), .o_pin(ext_pin));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge i_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a < 5'h18) m[a >> 2] = int'(d) & MSK[a >> 2];
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic ticks(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge i_clk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(5'(i * 4), 32'h0);
    wreg(5'h18, 32'hff);
    rdc(5'h18, 32'h0);
    repeat (4) begin
      v = rnd() & 32'hff;
      wreg(5'h04, v);
      wreg(5'h08, v ^ 32'h5a);
      rdc(5'h04, v);
      rdc(5'h08, v ^ 32'h5a);
    end
    ticks(30);
    rdc(5'h04, 32'(m[1]));
    wreg(5'h14, 32'h02);
    wreg(5'h00, 32'h20);
    wreg(5'h00, 32'ha0);
    rdc(5'h14, 32'h0a);
    chk({31'h0, pin_out}, 32'h1);
    chk({31'h0, pin_oe}, 32'h1);
    rdc(5'h0c, 32'h0);
    rdc(5'h04, 32'(m[1]));
    wreg(5'h00, 32'h80);
    rdc(5'h14, 32'h0a);
    chk({31'h0, pin_out}, 32'h0);
    wreg(5'h00, 32'h18);
    rdc(5'h14, 32'h0a);
    wreg(5'h00, 32'h00);
    wreg(5'h08, 32'h40);
    wreg(5'h04, 32'h40);
    wreg(5'h00, 32'h01);
    wreg(5'h00, 32'h00);
    rdc(5'h0c, 32'h0);
    wreg(5'h04, 32'h3c);
    wreg(5'h00, 32'h01);
    ticks(10);
    wreg(5'h00, 32'h00);
    rdc(5'h0c, 32'h2);
    wreg(5'h10, 32'h2);
    wreg(5'h14, 32'h06);
    ticks(2);
    chk({31'h0, cmp_irq}, 32'h1);
    wreg(5'h0c, 32'h0);
    ticks(2);
    chk({31'h0, cmp_irq}, 32'h1);
    wreg(5'h14, 32'h0e);
    ticks(2);
    chk({31'h0, cmp_irq}, 32'h0);
    wreg(5'h08, 32'h05);
    wreg(5'h04, 32'h00);
    wreg(5'h00, 32'h31);
    mx = 0;
    tg = 0;
    pl = pin_out;
    repeat (60) begin
      @(posedge i_clk);
      if (int'(count_value) > mx) mx = int'(count_value);
      if (pin_out !== pl) tg++;
      pl = pin_out;
    end
    chk(32'(mx), 32'h5);
    chk({31'h0, tg > 7}, 32'h1);
    chk({31'h0, cmp_irq}, 32'h1);
    wreg(5'h00, 32'h20);
    wreg(5'h0c, 32'h2);
    ticks(2);
    chk({31'h0, cmp_irq}, 32'h0);
    wreg(5'h10, 32'h1);
    wreg(5'h04, 32'hf8);
    chk({31'h0, ovf_irq}, 32'h0);
    wreg(5'h00, 32'h01);
    n = 0;
    while (count_value !== 8'h00 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    ticks(3);
    chk({31'h0, ovf_irq}, 32'h1);
    wreg(5'h00, 32'h00);
    wreg(5'h0c, 32'h1);
    ticks(2);
    chk({31'h0, ovf_irq}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wreg(5'h00, k ? 32'h09 : 32'h19);
      dec = 0;
      mx = 0;
      pc = count_value;
      repeat (600) begin
        @(posedge i_clk);
        if (count_value == pc - 8'h01) dec = 1;
        if (int'(count_value) > mx) mx = int'(count_value);
        pc = count_value;
      end
      chk(32'(dec), 32'(k));
      chk(32'(mx), 32'hff);
    end
    wreg(5'h00, 32'h00);
    wreg(5'h04, 32'h00);
    wreg(5'h00, 32'h02);
    ticks(80);
    wreg(5'h00, 32'h00);
    bus(1'b0, 5'h04, 32'h0);
    chk({31'h0, rv >= 32'h0a && rv <= 32'h0b}, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wreg(5'h04, 32'h00);
      wreg(5'h00, k ? 32'h06 : 32'h07);
      n = k ? fedges : edges;
      run <= 1'b1;
      ticks(60);
      run <= 1'b0;
      ticks(10);
      wreg(5'h00, 32'h00);
      rdc(5'h04, 32'(((k ? fedges : edges) - n) & 8'hff));
    end
    finish_test();
  end
endmodule
